// [rtl/accessory_pkg.sv]
// Constants and carrier types for the accessory-mode register group.
// Assumes register accesses arrive as decoded read and write strobes; set and clear are selected by address.
package accessory_pkg;

    localparam logic [5:0] CTRL_WRITE_ADDR = 6'h19;
    localparam logic [5:0] CTRL_SET_ADDR = 6'h1A;
    localparam logic [5:0] CTRL_CLEAR_ADDR = 6'h1B;
    localparam logic [5:0] IE_WRITE_ADDR = 6'h1D;
    localparam logic [5:0] IE_SET_ADDR = 6'h1E;
    localparam logic [5:0] IE_CLEAR_ADDR = 6'h1F;
    localparam logic [5:0] STATUS_ADDR = 6'h20;

    localparam int CTRL_ID_GROUND_BIT = 1;
    localparam int CTRL_UART_TX_BIT = 2;
    localparam int CTRL_UART_RX_BIT = 3;
    localparam int CTRL_LEFT_SPK_BIT = 4;
    localparam int CTRL_RIGHT_SPK_BIT = 5;
    localparam int CTRL_MIC_BIT = 6;
    localparam int CTRL_DATA2_REL_BIT = 7;
    localparam logic [7:0] CTRL_WRITABLE_MASK = 8'hFE;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    localparam int IE_OPEN_RISE_BIT = 0;
    localparam int IE_OPEN_FALL_BIT = 1;
    localparam int IE_CHARGER_BIT = 2;
    localparam int IE_RESISTOR_BIT = 5;
    localparam logic [7:0] IE_WRITABLE_MASK = 8'h27;
    localparam logic [7:0] IE_RESET = 8'h00;

    localparam int STAT_OPEN_BIT = 0;
    localparam int STAT_CHARGER_BIT = 1;
    localparam int STAT_CODE_LSB = 3;
    localparam int STAT_DONE_BIT = 6;

    localparam logic [2:0] RID_ZERO_OHM = 3'h0;
    localparam logic [2:0] RID_75_OHM = 3'h1;
    localparam logic [2:0] RID_102K_OHM = 3'h2;
    localparam logic [2:0] RID_FLOATING = 3'h5;
    localparam logic [2:0] RID_ERROR = 3'h7;

    localparam int CONV_TIME_NS = 282000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [5:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic idOpen;
        logic chargerCmp;
        logic [2:0] ridCode;
    } sense_type;

endpackage

// [rtl/edge_watch.sv]
// Remembers the previous level of each sense input and flags any change.
// Assumes inputs are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module edge_watch #(
    parameter int WIDTH = 2
) (
    input wire logic clk, // Clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic [WIDTH-1:0] level, // Levels watched.
    output logic [WIDTH-1:0] rise, // Level went 0 to 1.
    output logic [WIDTH-1:0] fall // Level went 1 to 0.
);
    typedef struct packed {
        logic primed;
        logic [WIDTH-1:0] prev;
    } state_type;
    state_type state_q;
    state_type state_d;

    always_comb
    begin
        state_d = state_q;
        state_d.prev = level;
        state_d.primed = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // No edges are reported until the first level has been captured.
    assign rise = state_q.primed ? (level & ~state_q.prev) : '0;
    assign fall = state_q.primed ? (~level & state_q.prev) : '0;
endmodule
`default_nettype wire

// [rtl/conv_timer.sv]
// Counts one resistor conversion period after a start pulse.
// Assumes start is a one-cycle pulse; a start while busy restarts.
`timescale 1ns/100ps
`default_nettype none
module conv_timer #(
    parameter int CYCLES = accessory_pkg::CONV_CYCLES
) (
    input wire logic clk, // Clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic start, // Begin a conversion.
    output logic busy, // Conversion running.
    output logic done // One-cycle pulse at the end.
);
    typedef struct packed {
        logic busy;
        logic done;
        logic [$clog2(CYCLES+1)-1:0] count;
    } state_type;
    state_type state_q;
    state_type state_d;

    always_comb
    begin
        state_d = state_q;
        state_d.done = 1'b0;
        if (start)
        begin
            state_d.busy = 1'b1;
            state_d.count = '0;
        end
        else if (state_q.busy)
        begin
            if (state_q.count == ($clog2(CYCLES+1))'(CYCLES - 1))
            begin
                state_d.busy = 1'b0;
                state_d.done = 1'b1;
            end
            else
            begin
                state_d.count = state_q.count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign busy = state_q.busy;
    assign done = state_q.done;
endmodule
`default_nettype wire

// [rtl/accessory_mode_control_regs.sv]
// Accessory-mode register group: switch control, interrupt enables, live status.
// Assumes decoded register strobes from the link side and synchronous analogue senses.
//
// How it works
// - Control register reads at 19h-1Bh; write 19h, set 1Ah, clear 1Bh.
// - Without receive routing, data line 1 is held high.
// - Transmit routing enable connects data line 0 to DM.
// - Receive routing enable connects DP to data line 1.
// - Left speaker switch connects DM to left speaker pin.
// - Right speaker or microphone switch connects DP to right speaker pin.
// - Bit 7 releases data line 2 in accessory mode instead of driving low.
// - In UART passthrough serial data also reaches enabled speaker pins.
// - Any audio switch disables the single-ended line receivers.
// - Interrupt enable register at 1Dh-1Fh with write, set, clear; resets zero.
// - Open-rise enable raises alt_int when ID starts floating.
// - Open-fall enable raises alt_int when ID stops floating.
// - Charger enable raises alt_int on any comparator change while sink current is enabled.
// - Resistor enable ORed with vendor enable raises alt_int on conversion done.
// - Status register at 20h is read-only and shows live values.
// - Status bit 1 shows comparator, valid only with sink current enabled.
// - Status bits 5:3 carry the measured ID resistor code.
// - Conversion done sets itself after a 282 us conversion.
// - Vendor code read clears done; status register read does not.
// - Unimplemented and reserved bits ignore writes and read zero.
`timescale 1ns/100ps
`default_nettype none
module accessory_mode_control_regs #(
    parameter int CONV_CYCLES = accessory_pkg::CONV_CYCLES
) (
    input wire logic clk, // Clock, 250 MHz.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire accessory_pkg::reg_req_type regReq, // Register access request.
    output logic [7:0] regRdata, // Read data, registered.
    output logic regRvalid, // Read data valid pulse.
    input wire logic accessoryMode, // Accessory mode bit from interface control.
    input wire logic vendorResistorIe, // Vendor copy of resistor interrupt enable.
    input wire logic vendorCodeRead, // Pulse: code read via vendor register.
    input wire logic convStart, // Pulse: begin an ID resistor conversion.
    input wire accessory_pkg::sense_type sense, // Live analogue sense results.
    input wire logic sinkCurrentEn, // Sink current enable.
    input wire logic uartTxIn, // Serial transmit data on data line 0.
    input wire logic dpRxIn, // Serial receive level from DP.
    output logic data1Out, // Level driven on data line 1.
    output logic data1Oe, // Data line 1 output enable.
    output logic data2Out, // Level driven on data line 2.
    output logic data2Oe, // Data line 2 output enable.
    output logic dmTxOut, // Serial transmit level toward DM.
    output logic dmTxOe, // DM driven by transmit route.
    output logic dmToLeftSpeaker, // Switch DM to left speaker pin.
    output logic dpToRightSpeaker, // Switch DP to right speaker pin.
    output logic leftSpeakerData, // UART data mirrored to left speaker.
    output logic rightSpeakerData, // UART data mirrored to right speaker.
    output logic seReceiverEn, // Single-ended receivers enabled.
    output logic idGroundOut, // ID pin low level.
    output logic idGroundOe, // ID pin drive enable.
    output logic altInt, // Pulse: alt_int for next RXCMD.
    output logic convBusy // Conversion in progress.
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] ie;
        logic done;
        logic [7:0] rdata;
        logic rvalid;
        logic altInt;
    } state_type;
    state_type state_q;
    state_type state_d;
    // Every check in this module runs on clk and rests while reset is held.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic [1:0] openRise;
    logic [1:0] openFall;
    logic convDone;
    logic [7:0] statusLive;
    logic chargerLive;

    edge_watch #(.WIDTH(2)) u_edges (
        .clk(clk),
        .rst_n(rst_n),
        .level({chargerLive, sense.idOpen}),
        .rise(openRise),
        .fall(openFall)
    );

    conv_timer #(.CYCLES(CONV_CYCLES)) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .start(convStart),
        .busy(convBusy),
        .done(convDone)
    );

    // Applies a write, set or clear to a register, keeping fixed-zero bits at zero.
    function automatic logic [7:0] apply_access(
        input logic [7:0] cur,
        input logic [7:0] data,
        input logic [1:0] op,
        input logic [7:0] mask
    );
        logic [7:0] res;
        res = cur;
        if (op == 2'h0)
        begin
            res = data;
        end
        else if (op == 2'h1)
        begin
            res = cur | data;
        end
        else if (op == 2'h2)
        begin
            res = cur & ~data;
        end
        return res & mask;
    endfunction

    // Comparator output is forced low while the sink current is off.
    assign chargerLive = sense.chargerCmp & sinkCurrentEn;

    always_comb
    begin
        statusLive = 8'h00;
        statusLive[accessory_pkg::STAT_OPEN_BIT] = sense.idOpen;
        statusLive[accessory_pkg::STAT_CHARGER_BIT] = chargerLive;
        statusLive[accessory_pkg::STAT_CODE_LSB +: 3] = sense.ridCode;
        statusLive[accessory_pkg::STAT_DONE_BIT] = state_q.done;
    end

    always_comb
    begin
        state_d = state_q;
        state_d.rvalid = 1'b0;
        state_d.altInt = 1'b0;
        if (regReq.wr)
        begin
            if (regReq.addr == accessory_pkg::CTRL_WRITE_ADDR)
            begin
                state_d.ctrl = apply_access(state_q.ctrl, regReq.wdata, 2'h0,
                    accessory_pkg::CTRL_WRITABLE_MASK);
            end
            else if (regReq.addr == accessory_pkg::CTRL_SET_ADDR)
            begin
                state_d.ctrl = apply_access(state_q.ctrl, regReq.wdata, 2'h1,
                    accessory_pkg::CTRL_WRITABLE_MASK);
            end
            else if (regReq.addr == accessory_pkg::CTRL_CLEAR_ADDR)
            begin
                state_d.ctrl = apply_access(state_q.ctrl, regReq.wdata, 2'h2,
                    accessory_pkg::CTRL_WRITABLE_MASK);
            end
            else if (regReq.addr == accessory_pkg::IE_WRITE_ADDR)
            begin
                state_d.ie = apply_access(state_q.ie, regReq.wdata, 2'h0,
                    accessory_pkg::IE_WRITABLE_MASK);
            end
            else if (regReq.addr == accessory_pkg::IE_SET_ADDR)
            begin
                state_d.ie = apply_access(state_q.ie, regReq.wdata, 2'h1,
                    accessory_pkg::IE_WRITABLE_MASK);
            end
            else if (regReq.addr == accessory_pkg::IE_CLEAR_ADDR)
            begin
                state_d.ie = apply_access(state_q.ie, regReq.wdata, 2'h2,
                    accessory_pkg::IE_WRITABLE_MASK);
            end
        end
        if (regReq.rd)
        begin
            state_d.rvalid = 1'b1;
            if (regReq.addr >= accessory_pkg::CTRL_WRITE_ADDR
                && regReq.addr <= accessory_pkg::CTRL_CLEAR_ADDR)
            begin
                state_d.rdata = state_q.ctrl;
            end
            else if (regReq.addr >= accessory_pkg::IE_WRITE_ADDR
                && regReq.addr <= accessory_pkg::IE_CLEAR_ADDR)
            begin
                state_d.rdata = state_q.ie;
            end
            else if (regReq.addr == accessory_pkg::STATUS_ADDR)
            begin
                state_d.rdata = statusLive;
            end
            else
            begin
                state_d.rdata = 8'h00;
            end
        end
        // A completing conversion wins over a vendor read in the same cycle.
        if (convDone)
        begin
            state_d.done = 1'b1;
        end
        else if (vendorCodeRead)
        begin
            state_d.done = 1'b0;
        end
        else if (convStart)
        begin
            state_d.done = 1'b0;
        end
        state_d.altInt = (state_q.ie[accessory_pkg::IE_OPEN_RISE_BIT] & openRise[0])
            | (state_q.ie[accessory_pkg::IE_OPEN_FALL_BIT] & openFall[0])
            | (state_q.ie[accessory_pkg::IE_CHARGER_BIT] & (openRise[1] | openFall[1]))
            | ((state_q.ie[accessory_pkg::IE_RESISTOR_BIT] | vendorResistorIe)
                & convDone);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q.ctrl <= accessory_pkg::CTRL_RESET;
            state_q.ie <= accessory_pkg::IE_RESET;
            state_q.done <= 1'b0;
            state_q.rdata <= 8'h00;
            state_q.rvalid <= 1'b0;
            state_q.altInt <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    logic txRoute;
    logic rxRoute;
    logic leftSw;
    logic rightSw;
    logic micSw;
    logic anyAudio;
    assign txRoute = state_q.ctrl[accessory_pkg::CTRL_UART_TX_BIT];
    assign rxRoute = state_q.ctrl[accessory_pkg::CTRL_UART_RX_BIT];
    assign leftSw = state_q.ctrl[accessory_pkg::CTRL_LEFT_SPK_BIT];
    assign rightSw = state_q.ctrl[accessory_pkg::CTRL_RIGHT_SPK_BIT];
    assign micSw = state_q.ctrl[accessory_pkg::CTRL_MIC_BIT];
    assign anyAudio = leftSw | rightSw | micSw;

    assign regRdata = state_q.rdata;
    assign regRvalid = state_q.rvalid;
    assign altInt = state_q.altInt;

    // Data line 1 carries DP when routed, otherwise a steady high, in accessory mode.
    assign data1Oe = accessoryMode;
    assign data1Out = rxRoute ? dpRxIn : 1'b1;
    // Data line 2 is driven low in accessory mode unless released.
    assign data2Oe = accessoryMode & ~state_q.ctrl[accessory_pkg::CTRL_DATA2_REL_BIT];
    assign data2Out = 1'b0;
    assign dmTxOe = accessoryMode & txRoute;
    assign dmTxOut = uartTxIn;
    assign dmToLeftSpeaker = leftSw;
    assign dpToRightSpeaker = rightSw | micSw;
    // UART levels follow the switched DM and DP lines onto the speaker pins.
    assign leftSpeakerData = (accessoryMode & txRoute & leftSw) ? uartTxIn : 1'b0;
    assign rightSpeakerData = (accessoryMode & (rightSw | micSw)) ? dpRxIn : 1'b0;
    assign seReceiverEn = ~anyAudio;
    assign idGroundOut = 1'b0;
    assign idGroundOe = state_q.ctrl[accessory_pkg::CTRL_ID_GROUND_BIT];

    a_ctrl_write: assert property (
        regReq.wr && regReq.addr == accessory_pkg::CTRL_WRITE_ADDR
        |=> state_q.ctrl == ($past(regReq.wdata) & accessory_pkg::CTRL_WRITABLE_MASK))
        else $error("control write not stored");
    a_ie_clear: assert property (
        regReq.wr && regReq.addr == accessory_pkg::IE_CLEAR_ADDR
        |=> (state_q.ie & $past(regReq.wdata)) == 8'h00)
        else $error("interrupt enable clear failed");
    a_ie_reserved: assert property (
        (state_q.ie & ~accessory_pkg::IE_WRITABLE_MASK) == 8'h00)
        else $error("unimplemented enable bit set");
    a_data1_high: assert property (
        !rxRoute |-> data1Out)
        else $error("data line 1 not high without receive route");
    a_right_switch: assert property (
        dpToRightSpeaker == (state_q.ctrl[5] | state_q.ctrl[6]))
        else $error("right speaker switch wrong");
    a_receiver_off: assert property (
        (state_q.ctrl[4] | state_q.ctrl[5] | state_q.ctrl[6]) |-> !seReceiverEn)
        else $error("receivers active with audio switch");
    a_open_rise_int: assert property (
        state_q.ie[0] && $rose(sense.idOpen) && $past(rst_n) |=> altInt)
        else $error("open rise interrupt missing");
    a_done_sticks: assert property (
        convDone |=> state_q.done ##1 (state_q.done || $past(vendorCodeRead || convStart)))
        else $error("conversion done not held");
    a_status_read: assert property (
        regReq.rd && regReq.addr == accessory_pkg::STATUS_ADDR
        |=> regRvalid && regRdata[6] == $past(state_q.done) && !regRdata[7])
        else $error("status read wrong");
    a_tx_route: assert property (
        dmTxOe == (accessoryMode && txRoute) && dmTxOut == uartTxIn)
        else $error("transmit route wrong");
    a_rx_route: assert property (
        accessoryMode && rxRoute |-> data1Oe && data1Out == dpRxIn)
        else $error("receive route wrong");
    a_left_switch: assert property (
        dmToLeftSpeaker == leftSw)
        else $error("left speaker switch wrong");
    a_data2_release: assert property (
        accessoryMode |-> data2Oe != state_q.ctrl[accessory_pkg::CTRL_DATA2_REL_BIT])
        else $error("data line 2 drive wrong");
    a_left_mirror: assert property (
        accessoryMode && txRoute && leftSw |-> leftSpeakerData == uartTxIn)
        else $error("left speaker data wrong");
    a_right_mirror: assert property (
        accessoryMode && (rightSw || micSw) |-> rightSpeakerData == dpRxIn)
        else $error("right speaker data wrong");
    a_open_fall_int: assert property (
        state_q.ie[1] && $fell(sense.idOpen) && $past(rst_n) |=> altInt)
        else $error("open fall interrupt missing");
    a_charger_int: assert property (
        state_q.ie[2] && $changed(chargerLive) && $past(rst_n) |=> altInt)
        else $error("charger interrupt missing");
    a_conv_int: assert property (
        (state_q.ie[5] || vendorResistorIe) && convDone |=> altInt)
        else $error("conversion interrupt missing");
    a_charger_gate: assert property (
        !sinkCurrentEn |-> !statusLive[accessory_pkg::STAT_CHARGER_BIT])
        else $error("comparator shown without sink current");
    a_vendor_clear: assert property (
        vendorCodeRead && !convDone |=> !state_q.done)
        else $error("vendor read did not clear done");
    a_id_ground: assert property (
        idGroundOe == state_q.ctrl[accessory_pkg::CTRL_ID_GROUND_BIT] && !idGroundOut)
        else $error("ID ground drive wrong");
    a_read_valid: assert property (
        regReq.rd |=> regRvalid)
        else $error("read valid missing");
    a_status_ro: assert property (
        regReq.wr && regReq.addr == accessory_pkg::STATUS_ADDR
        |=> $stable(state_q.ctrl) && $stable(state_q.ie))
        else $error("status write changed a register");
    a_status_code: assert property (
        regReq.rd && regReq.addr == accessory_pkg::STATUS_ADDR
        |=> regRdata[5:3] == $past(sense.ridCode))
        else $error("resistor code read wrong");
    a_ctrl_reserved: assert property (
        !state_q.ctrl[0] && !statusLive[2] && !statusLive[7])
        else $error("reserved bit set");
endmodule
`default_nettype wire

// [verification/link_model.sv]
// Link-side model that issues register writes and reads as decoded one-cycle strobes.
// Assumes read data arrives with regRvalid one cycle after the read strobe is taken.
`timescale 1ns/100ps
`default_nettype none
module link_model (
    input wire logic clk, // Clock.
    input wire logic [7:0] regRdata, // Read data.
    input wire logic regRvalid, // Read data valid.
    output var accessory_pkg::reg_req_type regReq // Register request.
);
    initial regReq = '0;

    // Released fields show inverted values so stale data cannot pass for a fresh one.
    task automatic write(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        regReq <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge clk);
        regReq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask

    task automatic read(input logic [5:0] a, output logic [7:0] d, output logic ok);
        @(posedge clk);
        regReq <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge clk);
        regReq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hFF};
        @(negedge clk);
        ok = regRvalid;
        d = regRdata;
    endtask
endmodule
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the accessory-mode register group.
// Assumes the link model in link_model.sv and a shortened conversion count.
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int CONV = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    accessory_pkg::reg_req_type regReq;
    accessory_pkg::sense_type sense = '0;
    logic [7:0] regRdata;
    logic regRvalid, data1Out, data1Oe, data2Out, data2Oe, dmTxOut, dmTxOe, dmToLeftSpeaker;
    logic dpToRightSpeaker, leftSpeakerData, rightSpeakerData, seReceiverEn, idGroundOut;
    logic idGroundOe, altInt, convBusy;
    logic accessoryMode = 1'b0, vendorResistorIe = 1'b0, vendorCodeRead = 1'b0;
    logic convStart = 1'b0, sinkCurrentEn = 1'b0, uartTxIn = 1'b0, dpRxIn = 1'b0;
    int fails = 0;
    int samplesChecked = 0;

    always #2 clk = ~clk;

    accessory_mode_control_regs #(.CONV_CYCLES(CONV)) i_dut (.clk(clk), .rst_n(rst_n),
        .regReq(regReq), .regRdata(regRdata), .regRvalid(regRvalid),
        .accessoryMode(accessoryMode), .vendorResistorIe(vendorResistorIe),
        .vendorCodeRead(vendorCodeRead), .convStart(convStart), .sense(sense),
        .sinkCurrentEn(sinkCurrentEn), .uartTxIn(uartTxIn), .dpRxIn(dpRxIn),
        .data1Out(data1Out), .data1Oe(data1Oe), .data2Out(data2Out), .data2Oe(data2Oe),
        .dmTxOut(dmTxOut), .dmTxOe(dmTxOe), .dmToLeftSpeaker(dmToLeftSpeaker),
        .dpToRightSpeaker(dpToRightSpeaker), .leftSpeakerData(leftSpeakerData),
        .rightSpeakerData(rightSpeakerData), .seReceiverEn(seReceiverEn),
        .idGroundOut(idGroundOut), .idGroundOe(idGroundOe), .altInt(altInt),
        .convBusy(convBusy));

    link_model i_link (.clk(clk), .regRdata(regRdata), .regRvalid(regRvalid), .regReq(regReq));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samplesChecked++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        i_link.write(a, d);
        @(negedge clk);
    endtask

    task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        i_link.read(a, d, ok);
        chk($sformatf("valid %h", a), 8'h01, ok);
        chk($sformatf("reg %h", a), exp, d);
    endtask

    task automatic rd3(input logic [5:0] a, input logic [7:0] exp);
        for (int i = 0; i < 3; i++)
            rdchk(a + i[5:0], exp);
    endtask

    task automatic t_regs;
        rd3(6'h19, 8'h00);
        rd3(6'h1D, 8'h00);
        rdchk(6'h21, 8'h00);
        wr(6'h19, 8'hFF);
        rd3(6'h19, 8'hFE);
        wr(6'h1B, 8'h0C);
        rdchk(6'h19, 8'hF2);
        wr(6'h1A, 8'h05);
        rd3(6'h19, 8'hF6);
        wr(6'h19, 8'h00);
        wr(6'h1D, 8'hFF);
        rd3(6'h1D, 8'h27);
        wr(6'h1F, 8'h04);
        rdchk(6'h1E, 8'h23);
        wr(6'h1E, 8'h5C);
        rdchk(6'h1F, 8'h27);
        wr(6'h1D, 8'h00);
        $display("test registers done");
    endtask

    task automatic t_uart;
        wr(6'h19, 8'h0C);
        @(posedge clk) accessoryMode <= 1'b1;
        for (int v = 0; v < 2; v++)
        begin
            @(posedge clk) uartTxIn <= v[0];
            dpRxIn <= !v[0];
            @(negedge clk);
            chk("dm tx", {7'h0, v[0]} | 8'h02, {dmTxOe, dmTxOut});
            chk("data1 rx", {7'h0, !v[0]} | 8'h02, {data1Oe, data1Out});
        end
        wr(6'h1B, 8'h08);
        chk("data1 idle", 8'h03, {data1Oe, data1Out});
        chk("data2 low", 8'h02, {data2Oe, data2Out});
        wr(6'h1A, 8'h92);
        chk("data2 oe", 8'h00, data2Oe);
        chk("id drive", 8'h02, {idGroundOe, idGroundOut});
        chk("spk left hi", 8'h01, leftSpeakerData);
        @(posedge clk) uartTxIn <= 1'b0;
        @(negedge clk);
        chk("spk left lo", 8'h00, leftSpeakerData);
        wr(6'h1A, 8'h40);
        for (int v = 0; v < 2; v++)
        begin
            @(posedge clk) dpRxIn <= v[0];
            @(negedge clk);
            chk("spk right", {7'h0, v[0]}, rightSpeakerData);
        end
        wr(6'h19, 8'h00);
        chk("id release", 8'h00, idGroundOe);
        @(posedge clk) accessoryMode <= 1'b0;
        $display("test uart done");
    endtask

    task automatic t_audio;
        logic [7:0] vals [5] = '{8'h10, 8'h20, 8'h40, 8'h60, 8'h00};
        foreach (vals[i])
        begin
            wr(6'h19, vals[i]);
            chk("left sw", {7'h0, vals[i][4]}, dmToLeftSpeaker);
            chk("right sw", {7'h0, |vals[i][6:5]}, dpToRightSpeaker);
            chk("se rx", {7'h0, ~|vals[i][6:4]}, seReceiverEn);
        end
        $display("test audio done");
    endtask

    task automatic ev(input string what, input logic [7:0] ie,
        input accessory_pkg::sense_type s, input int exp);
        int n = 0;
        wr(6'h1D, ie);
        @(posedge clk) sense <= s;
        repeat (6)
        begin
            @(negedge clk);
            if (altInt === 1'b1)
                n++;
        end
        chk(what, exp[7:0], n[7:0]);
    endtask

    task automatic t_events;
        @(posedge clk) sinkCurrentEn <= 1'b1;
        ev("open rise", 8'h01, 5'h10, 1);
        ev("fall masked", 8'h01, 5'h00, 0);
        ev("rise masked", 8'h02, 5'h10, 0);
        ev("open fall", 8'h02, 5'h00, 1);
        ev("cmp up", 8'h04, 5'h08, 1);
        ev("cmp down", 8'h04, 5'h00, 1);
        ev("cmp masked", 8'h00, 5'h08, 0);
        $display("test events done");
    endtask

    task automatic t_status;
        logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h7};
        foreach (codes[i])
        begin
            @(posedge clk) sense <= {2'b11, codes[i]};
            sinkCurrentEn <= codes[i][0];
            rdchk(6'h20, {2'b00, codes[i], 1'b0, codes[i][0], 1'b1});
        end
        wr(6'h20, 8'hFF);
        rdchk(6'h20, 8'h3B);
        $display("test status done");
    endtask

    task automatic conv(input int exp);
        int n = 0;
        @(posedge clk) convStart <= 1'b1;
        @(posedge clk) convStart <= 1'b0;
        @(negedge clk);
        chk("busy", 8'h01, convBusy);
        while (n < CONV + 8 && altInt !== 1'b1)
        begin
            @(negedge clk);
            n++;
        end
        chk("conv int", exp[7:0], {7'h0, altInt === 1'b1});
        if (exp == 1)
            chk("conv time", 8'h01, {7'h0, n >= CONV - 1 && n <= CONV + 3});
    endtask

    task automatic t_conv;
        @(posedge clk) sense <= 5'h02;
        sinkCurrentEn <= 1'b0;
        wr(6'h1D, 8'h20);
        conv(1);
        rdchk(6'h20, 8'h50);
        rdchk(6'h20, 8'h50);
        @(posedge clk) vendorCodeRead <= 1'b1;
        @(posedge clk) vendorCodeRead <= 1'b0;
        rdchk(6'h20, 8'h10);
        wr(6'h1F, 8'h20);
        @(posedge clk) vendorResistorIe <= 1'b1;
        conv(1);
        @(posedge clk) vendorResistorIe <= 1'b0;
        conv(0);
        $display("test conversion done");
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        chk("reset se rx", 8'h01, seReceiverEn);
        chk("reset id oe", 8'h00, idGroundOe);
        rst_n <= 1'b1;
        t_regs();
        t_uart();
        t_audio();
        t_events();
        t_status();
        t_conv();
        stop_test();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        fails++;
        stop_test();
    end
endmodule
`default_nettype wire
